// >>> bench/fwp_host.sv
`include "fwp_consts.svh"

module fwp_host
    import fwp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst_n,
    output fwp_pins_t pins,
    output logic [5:0] addr,
    output logic [15:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic ce, we, oe, wp, rst_lvl, vpp;

    // Flash reset follows the system reset as well as any local request
    assign pins = '{ce, we, oe, wp, rst_lvl & sys_rst_n, vpp};

    initial
    begin
        {ce, we, oe, wp, rst_lvl, vpp} = 6'h3f;
        addr = 6'h00;
        dq = 16'h0000;
    end

    // ce_hold high keeps chip-enable inactive so the strobe must be ignored
    task automatic write_word(input logic [5:0] blk, input logic [15:0] data,
                              input logic ce_hold);
        @(negedge clk);
        addr = blk;
        dq = data;
        ce = ce_hold;
        we = 1'b0;
        repeat (2) @(negedge clk);
        {ce, we} = 2'b11;
        // Address and data held past the two-stage input sync
        repeat (4) @(negedge clk);
        dq = ~data;
        repeat (4) @(negedge clk);
    endtask

    task automatic read_word(input logic [5:0] blk, input logic ff_first);
        if (ff_first)
            write_word(6'h00, {8'h00, `FWP_CMD_READ_ARRAY}, 1'b0);
        @(negedge clk);
        addr = blk;
        {ce, oe} = 2'b00;
    endtask

    task automatic set_lvl(input logic wp_v, vpp_v, rst_v, ce_v, oe_v);
        @(negedge clk);
        {wp, vpp, rst_lvl, ce, oe} = {wp_v, vpp_v, rst_v, ce_v, oe_v};
    endtask
endmodule

// >>> bench/fwp_tb.sv
`include "fwp_consts.svh"

module testbench
    import fwp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, resetn, top_cfg, dens_16m, dq_oe_n, array_we, array_erase, busy;
    fwp_pins_t pins;
    logic [5:0] addr_blk, array_blk;
    logic [15:0] dq_in, dq_out, array_rdata;
    logic [7:0] status;
    logic [1:0] pwr_mode;
    int err_total, n_tests, n_we, n_er, cyc;
    // {top, 16 Mbit, lockable, block}
    logic [8:0] lk [14] = '{9'h1e5, 9'h1de, 9'h19f, 9'h1a4, 9'h155, 9'h14e, 9'h10f,
                            9'h0c1, 9'h0c8, 9'h0e6, 9'h087, 9'h082, 9'h056, 9'h007};

    assign array_rdata = {10'h2d1, addr_blk};

    fwp_host host (.clk(clk), .sys_rst_n(resetn), .pins(pins), .addr(addr_blk), .dq(dq_in));

    fwp_ctrl #(.OP_CYCLES(16)) DUT (.clk(clk), .resetn(resetn), .ce_n(pins.ce_n),
        .we_n(pins.we_n), .oe_n(pins.oe_n), .wp_n(pins.wp_n), .rst_n(pins.rst_n),
        .vpp_ok(pins.vpp_ok), .top_cfg(top_cfg), .dens_16m(dens_16m), .addr_blk(addr_blk),
        .dq_in(dq_in), .array_rdata(array_rdata), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .status(status), .array_we(array_we), .array_erase(array_erase),
        .array_blk(array_blk), .pwr_mode(pwr_mode), .busy(busy));

    always #10 clk = ~clk;

    // ----------------------------------------
    // Pulse counting and hang guard
    // ----------------------------------------
    always @(posedge clk)
    begin
        n_we += (array_we === 1'b1);
        n_er += (array_erase === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            $display("wrong value at %0t: run did not finish", $time);
            end_sim();
        end
    end

    task automatic end_sim();
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_v(input logic [15:0] got, exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, exp, input string what);
        chk_v({15'h0, got}, {15'h0, exp}, what);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 200)
        begin
            @(negedge clk);
            k++;
        end
        chk_b(k < 200, 1'b1, "busy ends");
    endtask

    task automatic cmd(input logic [5:0] blk, input logic [7:0] c);
        host.write_word(blk, {8'h00, c}, 1'b0);
        wait_idle();
    endtask

    task automatic prog(input logic [5:0] blk, input logic ch);
        host.write_word(blk, {8'h00, `FWP_CMD_PROGRAM}, ch);
        host.write_word(blk, 16'h1234, ch);
        wait_idle();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_read();
        host.read_word(6'h05, 1'b0);
        repeat (4) @(negedge clk);
        chk_b(pwr_mode === FWP_PWR_ACTIVE || pwr_mode === FWP_PWR_SAVE, 1'b1, "active");
        repeat (10) @(negedge clk);
        chk_v({14'h0, pwr_mode}, {14'h0, FWP_PWR_SAVE}, "power save");
        chk_v(dq_out, {10'h2d1, 6'h05}, "read data");
        chk_b(dq_oe_n, 1'b0, "read drive");
        host.read_word(6'h06, 1'b0);
        repeat (4) @(negedge clk);
        chk_v(dq_out, {10'h2d1, 6'h06}, "new location");
        host.set_lvl(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        repeat (6) @(negedge clk);
        chk_v({14'h0, pwr_mode}, {14'h0, FWP_PWR_STANDBY}, "standby");
        chk_b(dq_oe_n, 1'b1, "standby release");
        host.set_lvl(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_lock();
        int nb;
        logic lx;
        for (int w = 0; w < 2; w++)
        begin
            host.set_lvl(w[0], 1'b1, 1'b1, 1'b1, 1'b1);
            for (int i = 0; i < 14; i++)
            begin
                {top_cfg, dens_16m} = lk[i][8:7];
                lx = lk[i][6] & ~w[0];
                nb = n_we;
                prog(lk[i][5:0], 1'b0);
                chk_b(status[`FWP_SR_LOCK_ERR], lx, "lock err");
                chk_v(16'(n_we - nb), {15'h0, ~lx}, "program pulse");
                if (!lx)
                    chk_v({10'h0, array_blk}, {10'h0, lk[i][5:0]}, "target");
                cmd(6'h00, `FWP_CMD_CLEAR_STATUS);
            end
        end
    endtask

    task automatic t_supply();
        int nw, ne;
        logic [7:0] sx;
        nw = n_we;
        ne = n_er;
        {top_cfg, dens_16m} = 2'b11;
        host.set_lvl(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        prog(6'd31, 1'b0);
        chk_b(status[`FWP_SR_SUPPLY_ERR], 1'b1, "supply err");
        cmd(6'd31, `FWP_CMD_READ_ARRAY);
        cmd(6'd31, `FWP_CMD_READ_STATUS);
        host.read_word(6'd31, 1'b0);
        repeat (4) @(negedge clk);
        sx = `FWP_SR_RESET | (8'h01 << `FWP_SR_PROG_ERR) | (8'h01 << `FWP_SR_SUPPLY_ERR);
        chk_v(dq_out, {8'h00, sx}, "status read");
        host.set_lvl(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        cmd(6'd2, `FWP_CMD_ERASE_SETUP);
        cmd(6'd2, `FWP_CMD_ERASE_CONFIRM);
        chk_v(16'(n_we + n_er - nw - ne), 16'h0, "no array change");
        host.set_lvl(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        repeat (6) @(negedge clk);
        chk_b(status[`FWP_SR_SUPPLY_ERR], 1'b1, "sticky err");
        cmd(6'h00, `FWP_CMD_CLEAR_STATUS);
        chk_v({8'h0, status}, {8'h0, `FWP_SR_RESET}, "cleared");
    endtask

    task automatic t_erase();
        int ne;
        ne = n_er;
        cmd(6'd31, `FWP_CMD_ERASE_SETUP);
        cmd(6'd31, `FWP_CMD_PROGRAM);
        chk_b(status[`FWP_SR_ERASE_ERR], 1'b1, "bad sequence");
        chk_v(16'(n_er - ne), 16'h0, "no erase");
        cmd(6'h00, `FWP_CMD_CLEAR_STATUS);
        cmd(6'd31, `FWP_CMD_ERASE_SETUP);
        cmd(6'd31, `FWP_CMD_ERASE_CONFIRM);
        chk_v(16'(n_er - ne), 16'h1, "erase");
        chk_v({10'h0, array_blk}, 16'd31, "erase target");
    endtask

    task automatic t_gate_rst();
        int nw;
        nw = n_we;
        prog(6'd31, 1'b1);
        chk_v({8'h0, status}, {8'h0, `FWP_SR_RESET}, "gated write");
        host.set_lvl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        repeat (4) @(negedge clk);
        chk_v({14'h0, pwr_mode}, {14'h0, FWP_PWR_DISABLED}, "disabled");
        prog(6'd31, 1'b0);
        chk_v(16'(n_we - nw), 16'h0, "writes in reset");
        host.set_lvl(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        repeat (4) @(negedge clk);
        cmd(6'h00, `FWP_CMD_CLEAR_STATUS);
    endtask

    task automatic t_ce_op();
        int nw;
        nw = n_we;
        host.write_word(6'd31, {8'h00, `FWP_CMD_PROGRAM}, 1'b0);
        host.write_word(6'd31, 16'h5a5a, 1'b0);
        chk_b(busy, 1'b1, "op running");
        chk_v({14'h0, pwr_mode}, {14'h0, FWP_PWR_ACTIVE}, "active in op");
        wait_idle();
        chk_v(16'(n_we - nw), 16'h1, "op done");
        cmd(6'h00, `FWP_CMD_READ_ARRAY);
        repeat (4) @(negedge clk);
        chk_v({14'h0, pwr_mode}, {14'h0, FWP_PWR_STANDBY}, "standby after");
    endtask

    initial
    begin
        {clk, resetn, top_cfg, dens_16m} = 4'b0011;
        {err_total, n_tests, n_we, n_er, cyc} = '0;
        repeat (10) @(negedge clk);
        chk_v({8'h0, status}, {8'h0, `FWP_SR_RESET}, "reset status");
        chk_v({14'h0, pwr_mode}, {14'h0, FWP_PWR_DISABLED}, "reset mode");
        chk_b(dq_oe_n, 1'b1, "reset drive");
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_read();
        t_lock();
        t_supply();
        t_erase();
        t_gate_rst();
        t_ce_op();
        end_sim();
    end
endmodule

// >>> core/fwp_consts.svh
`ifndef FWP_CONSTS_SVH
`define FWP_CONSTS_SVH

// Command codes seen on the low data byte
`define FWP_CMD_READ_ARRAY 8'hff
`define FWP_CMD_READ_STATUS 8'h70
`define FWP_CMD_CLEAR_STATUS 8'h50
`define FWP_CMD_PROGRAM 8'h40
`define FWP_CMD_ERASE_SETUP 8'h20
`define FWP_CMD_ERASE_CONFIRM 8'hd0

// Status register bit positions
`define FWP_SR_READY 7
`define FWP_SR_ERASE_ERR 5
`define FWP_SR_PROG_ERR 4
`define FWP_SR_SUPPLY_ERR 3
`define FWP_SR_LOCK_ERR 1
`define FWP_SR_RESET 8'h80

// Block map
`define FWP_BLOCKS_16M 39
`define FWP_BLOCKS_8M 23
`define FWP_BLK_W 6

// Operation time
`define FWP_OP_TIME_NS 2000
`define FWP_CLK_NS 20
`define FWP_OP_CYCLES (`FWP_OP_TIME_NS / `FWP_CLK_NS)

`endif

// >>> core/fwp_ctrl.sv
// What this block does
// - Supply below lockout level refuses every erase/program and sets supply error bit.
// - Write-protect low refuses erase/program on lockable blocks, reporting it in status.
// - Top layout lockable: blocks 37,38,0-30 (16M) or 21,22,0-14 (8M).
// - Bottom layout lockable: blocks 0,1,8-38 (16M) or 0,1,8-22 (8M).
// - Blocks outside the locked set work normally when supply is adequate.
// - Write-protect high with good supply unlocks all; locking follows that pin and reset only.
// - Reset low keeps device disabled and all blocks locked.
// - Chip-enable low and reset high means active mode.
// - After an array read, go to power save, keeping read data driven.
// - Chip-enable high in read-array mode gives standby with data outputs released.
// - Chip-enable high during an operation: finish it, then stay active in read-status mode until a read-array command.
// - Command write accepted only while write-enable and chip-enable both low.
// - Array changes only after a full valid two-step command sequence.
// - Command interface starts in read-array mode after power-up or reset.
`include "fwp_consts.svh"

module fwp_ctrl
    import fwp_pkg::*;
#(
    parameter int OP_CYCLES = `FWP_OP_CYCLES
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic wp_n,
    input wire logic rst_n,
    input wire logic vpp_ok,
    input wire logic top_cfg,
    input wire logic dens_16m,
    input wire logic [`FWP_BLK_W-1:0] addr_blk,
    input wire logic [15:0] dq_in,
    input wire logic [15:0] array_rdata,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    output logic [7:0] status,
    output logic array_we,
    output logic array_erase,
    output logic [`FWP_BLK_W-1:0] array_blk,
    output logic [1:0] pwr_mode,
    output logic busy
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    fwp_pins_t pins;
    logic [5:0] pin_raw;
    logic [5:0] pin_sync;
    logic [`FWP_BLK_W-1:0] blk_s;
    logic [15:0] dq_s;

    assign pin_raw = {ce_n, we_n, oe_n, wp_n, rst_n, vpp_ok};

    fwp_sync #(.W(6)) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    fwp_sync #(.W(`FWP_BLK_W + 16)) u_bus_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({addr_blk, dq_in}),
        .sync_out({blk_s, dq_s})
    );

    assign pins = fwp_pins_t'(pin_sync);

    // ----------------------------------------------------------------
    // Lock decode
    // ----------------------------------------------------------------
    logic blk_locked;

    fwp_lock u_lock (
        .top_cfg(top_cfg),
        .dens_16m(dens_16m),
        .blk(blk_s),
        .wp_n(pins.wp_n),
        .rst_n(pins.rst_n),
        .locked(blk_locked)
    );

    // ----------------------------------------------------------------
    // Command interface and operation engine
    // ----------------------------------------------------------------
    logic we_q;
    logic we_d;
    logic wr_strobe;
    logic setup_q;
    logic setup_d;
    logic erase_q;
    logic erase_d;
    fwp_ci_mode_t mode_q;
    fwp_ci_mode_t mode_d;
    logic [7:0] sr_q;
    logic [7:0] sr_d;
    logic [15:0] op_cnt_q;
    logic [15:0] op_cnt_d;
    logic aw_q;
    logic aw_d;
    logic ae_q;
    logic ae_d;
    logic [`FWP_BLK_W-1:0] ablk_q;
    logic [`FWP_BLK_W-1:0] ablk_d;
    logic [7:0] cmd;
    logic op_busy;
    logic busy_q;
    logic busy_d;

    assign cmd = dq_s[7:0];
    assign op_busy = (op_cnt_q != 16'h0000);
    // Write taken on the rising edge of the combined strobe
    assign wr_strobe = we_q && (pins.we_n || pins.ce_n || !pins.rst_n);

    always_comb
    begin
        we_d = !pins.we_n && !pins.ce_n && pins.rst_n;
        setup_d = setup_q;
        erase_d = erase_q;
        mode_d = mode_q;
        sr_d = sr_q;
        op_cnt_d = op_cnt_q;
        aw_d = 1'b0;
        ae_d = 1'b0;
        ablk_d = ablk_q;
        if (op_busy)
        begin
            // Runs to the end whatever chip-enable does
            op_cnt_d = op_cnt_q - 16'h0001;
            if (op_cnt_q == 16'h0001)
                sr_d[`FWP_SR_READY] = 1'b1;
        end
        if (!pins.rst_n)
        begin
            setup_d = 1'b0;
            mode_d = FWP_CI_READ_ARRAY;
        end
        else if (wr_strobe && !op_busy)
        begin
            if (setup_q)
            begin
                // Second step of the sequence
                setup_d = 1'b0;
                mode_d = FWP_CI_READ_STATUS;
                if (erase_q && cmd != `FWP_CMD_ERASE_CONFIRM)
                begin
                    sr_d[`FWP_SR_ERASE_ERR] = 1'b1;
                    sr_d[`FWP_SR_PROG_ERR] = 1'b1;
                end
                else if (!pins.vpp_ok)
                begin
                    sr_d[`FWP_SR_SUPPLY_ERR] = 1'b1;
                    sr_d[erase_q ? `FWP_SR_ERASE_ERR : `FWP_SR_PROG_ERR] = 1'b1;
                end
                else if (blk_locked)
                begin
                    sr_d[`FWP_SR_LOCK_ERR] = 1'b1;
                    sr_d[erase_q ? `FWP_SR_ERASE_ERR : `FWP_SR_PROG_ERR] = 1'b1;
                end
                else
                begin
                    // Only a full valid sequence touches the array
                    aw_d = !erase_q;
                    ae_d = erase_q;
                    ablk_d = blk_s;
                    sr_d[`FWP_SR_READY] = 1'b0;
                    op_cnt_d = 16'(OP_CYCLES);
                end
            end
            else
            begin
                unique case (cmd)
                    `FWP_CMD_READ_ARRAY: mode_d = FWP_CI_READ_ARRAY;
                    `FWP_CMD_READ_STATUS: mode_d = FWP_CI_READ_STATUS;
                    `FWP_CMD_CLEAR_STATUS: sr_d = sr_d & 8'h80;
                    `FWP_CMD_PROGRAM:
                    begin
                        setup_d = 1'b1;
                        erase_d = 1'b0;
                    end
                    `FWP_CMD_ERASE_SETUP:
                    begin
                        setup_d = 1'b1;
                        erase_d = 1'b1;
                    end
                    default: mode_d = mode_q;
                endcase
            end
        end
        busy_d = !sr_d[`FWP_SR_READY];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            we_q <= 1'b0;
            setup_q <= 1'b0;
            erase_q <= 1'b0;
            mode_q <= FWP_CI_READ_ARRAY;
            sr_q <= `FWP_SR_RESET;
            op_cnt_q <= 16'h0000;
            aw_q <= 1'b0;
            ae_q <= 1'b0;
            ablk_q <= '0;
            busy_q <= 1'b0;
        end
        else
        begin
            we_q <= we_d;
            setup_q <= setup_d;
            erase_q <= erase_d;
            mode_q <= mode_d;
            sr_q <= sr_d;
            op_cnt_q <= op_cnt_d;
            aw_q <= aw_d;
            ae_q <= ae_d;
            ablk_q <= ablk_d;
            busy_q <= busy_d;
        end
    end

    // ----------------------------------------------------------------
    // Power modes and data outputs
    // ----------------------------------------------------------------
    fwp_pwr_t pwr_q;
    fwp_pwr_t pwr_d;
    logic [15:0] dq_q;
    logic [15:0] dq_d;
    logic oe_q;
    logic oe_d;
    logic [`FWP_BLK_W-1:0] last_blk_q;
    logic [`FWP_BLK_W-1:0] last_blk_d;

    always_comb
    begin
        pwr_d = pwr_q;
        dq_d = dq_q;
        last_blk_d = last_blk_q;
        oe_d = 1'b1;
        if (!pins.rst_n)
            pwr_d = FWP_PWR_DISABLED;
        else if (pins.ce_n && !op_busy && !aw_d && !ae_d && mode_q == FWP_CI_READ_ARRAY)
            pwr_d = FWP_PWR_STANDBY;
        else if (!pins.ce_n)
        begin
            pwr_d = FWP_PWR_ACTIVE;
            if (!pins.oe_n && pins.we_n)
            begin
                oe_d = 1'b0;
                if (mode_q == FWP_CI_READ_STATUS)
                    dq_d = {8'h00, sr_q};
                else if (pwr_q == FWP_PWR_SAVE && blk_s == last_blk_q)
                    pwr_d = FWP_PWR_SAVE;
                else
                begin
                    dq_d = array_rdata;
                    last_blk_d = blk_s;
                    pwr_d = FWP_PWR_SAVE;
                end
            end
        end
        else
            pwr_d = FWP_PWR_ACTIVE;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwr_q <= FWP_PWR_DISABLED;
            dq_q <= 16'h0000;
            oe_q <= 1'b1;
            last_blk_q <= '0;
        end
        else
        begin
            pwr_q <= pwr_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            last_blk_q <= last_blk_d;
        end
    end

    assign dq_out = dq_q;
    assign dq_oe_n = oe_q;
    assign status = sr_q;
    assign array_we = aw_q;
    assign array_erase = ae_q;
    assign array_blk = ablk_q;
    assign pwr_mode = pwr_q;
    assign busy = busy_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_supply_refuse: assert property (@(posedge clk) disable iff (!resetn)
        (setup_q && wr_strobe && !op_busy && pins.rst_n && !pins.vpp_ok
            && (!erase_q || cmd == `FWP_CMD_ERASE_CONFIRM))
        |=> sr_q[`FWP_SR_SUPPLY_ERR] && !aw_q && !ae_q)
        else $error("supply lockout did not refuse");
    a_lock_refuse: assert property (@(posedge clk) disable iff (!resetn)
        (setup_q && wr_strobe && !op_busy && pins.vpp_ok && blk_locked)
        |=> !aw_q && !ae_q)
        else $error("locked block was altered");
    a_reset_locks: assert property (@(posedge clk) disable iff (!resetn)
        !pins.rst_n |=> pwr_q == FWP_PWR_DISABLED && !aw_q && !ae_q)
        else $error("reset did not disable device");
    a_standby_hiz: assert property (@(posedge clk) disable iff (!resetn)
        pwr_q == FWP_PWR_STANDBY |-> dq_oe_n)
        else $error("outputs driven in standby");
    a_op_finishes: assert property (@(posedge clk) disable iff (!resetn)
        op_busy |-> pwr_q != FWP_PWR_STANDBY || $past(pwr_q) == FWP_PWR_STANDBY)
        else $error("standby entered mid operation");
    a_clear_sticky: assert property (@(posedge clk) disable iff (!resetn)
        sr_q[`FWP_SR_SUPPLY_ERR] && !(wr_strobe && cmd == `FWP_CMD_CLEAR_STATUS)
        |=> sr_q[`FWP_SR_SUPPLY_ERR])
        else $error("error flag dropped without clear");
    a_write_needs_ce: assert property (@(posedge clk) disable iff (!resetn)
        we_q |-> !$past(pins.ce_n) && !$past(pins.we_n))
        else $error("write taken without both strobes");
    a_two_step: assert property (@(posedge clk) disable iff (!resetn)
        (aw_q || ae_q) |-> $past(setup_q, 1))
        else $error("array altered without setup");
endmodule

// >>> core/fwp_lock.sv
`include "fwp_consts.svh"

module fwp_lock
    import fwp_pkg::*;
(
    input wire logic top_cfg,
    input wire logic dens_16m,
    input wire logic [`FWP_BLK_W-1:0] blk,
    input wire logic wp_n,
    input wire logic rst_n,
    output logic locked
);
    logic lockable;

    always_comb
    begin
        if (top_cfg)
        begin
            if (dens_16m)
                lockable = (blk <= 6'h1e) || (blk == 6'h25) || (blk == 6'h26);
            else
                lockable = (blk <= 6'h0e) || (blk == 6'h15) || (blk == 6'h16);
        end
        else
        begin
            if (dens_16m)
                lockable = (blk <= 6'h01) || ((blk >= 6'h08) && (blk <= 6'h26));
            else
                lockable = (blk <= 6'h01) || ((blk >= 6'h08) && (blk <= 6'h16));
        end
        // Reset locks all; otherwise the protect pin decides for lockable blocks
        locked = !rst_n || (!wp_n && lockable);
    end
endmodule

// >>> core/fwp_pkg.sv
package fwp_pkg;
    typedef enum logic [1:0] {
        FWP_PWR_ACTIVE,
        FWP_PWR_SAVE,
        FWP_PWR_STANDBY,
        FWP_PWR_DISABLED
    } fwp_pwr_t;

    typedef enum logic [1:0] {
        FWP_CI_READ_ARRAY,
        FWP_CI_READ_STATUS
    } fwp_ci_mode_t;

    // Host-side pins, already synchronised
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic wp_n;
        logic rst_n;
        logic vpp_ok;
    } fwp_pins_t;
endpackage

// >>> core/fwp_sync.sv
module fwp_sync
    import fwp_pkg::*;
#(
    parameter int W = 6
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Reset value is all ones: control pins idle high
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= '1;
            sync_q <= '1;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule
